// File: pkg/acc_unit_defines.svh
// constants of the accumulator add/subtract unit: offsets, fields, resets, figures
`ifndef ACC_UNIT_DEFINES_SVH
`define ACC_UNIT_DEFINES_SVH

// ====================================================================
// register port
`define REG_ADDR_W 4
`define REG_ACC 4'h0
`define REG_OPERAND 4'h1
`define REG_CMD 4'h2
`define REG_STATUS 4'h3

// ====================================================================
// command word fields
`define CMD_OP_MSB 1
`define CMD_OP_LSB 0
`define CMD_SRC_MSB 3
`define CMD_SRC_LSB 2

// ====================================================================
// status word fields
`define FLG_W 9
`define FLG_ZERO 0
`define FLG_CARRY16 1
`define FLG_CARRY32 2
`define FLG_NEG 3
`define FLG_BADPTR 4
`define FLG_INVFLT 5
`define FLG_SIGNERR 6
`define FLG_UNDERFLOW 7
`define FLG_OPFMT 8
`define STS_BUSY 9

// ====================================================================
// reset values
`define ACC_RST 32'h0000_0000
`define OPERAND_RST 32'h0000_0000
`define FLG_RST 9'h000
`define RD_RST 32'h0000_0000

// ====================================================================
// number formats
`define FP_EXP_ALL1 8'hFF
`define FP_EXP_ZERO 8'h00
`define FP_EXP_OVF 10'h0FF
`define FP_EXP_ONE 10'h001
`define FP_ALIGN_LIMIT 9'h018
`define FP_MANT_W 24
`define BCD_RADIX 5'h0A
`define BCD_DIGIT_MAX 4'h9
`define BCD_DIGITS 8
`define HALF_W 16

`endif

// File: pkg/acc_unit_pkg.sv
// types shared by the accumulator add/subtract unit
`default_nettype none

package acc_unit_pkg;

  // ==================================================================
  // operations and operand sources
  typedef enum logic [1:0] {
    add_real_op = 2'h0,
    sub_bcd16_op = 2'h1,
    sub_bcd32_op = 2'h2,
    sub_real_op = 2'h3
  } op_t;

  typedef enum logic [1:0] {
    src_direct = 2'h0,
    src_pointer = 2'h1,
    src_constant = 2'h2,
    src_spare = 2'h3
  } src_t;

  // ==================================================================
  // sequencer states
  typedef enum logic [1:0] {
    st_idle = 2'b01,
    st_exec = 2'b10
  } fsm_t;

endpackage : acc_unit_pkg

`default_nettype wire

// File: rtl/bcd_digit_sub.sv
// one decimal digit of a borrow-chained BCD subtractor
`default_nettype none
`include "acc_unit_defines.svh"

module bcd_digit_sub #(
  parameter int DIGIT_W = 4
) (
  // operands
  input wire logic [DIGIT_W-1:0] minuend_in,
  input wire logic [DIGIT_W-1:0] subtrahend_in,
  input wire logic borrow_in,
  // results
  output logic [DIGIT_W-1:0] diff_out,
  output logic borrow_out,
  output logic bad_digit_out
);

  logic [DIGIT_W:0] raw;

  // ==================================================================
  // digit arithmetic
  always_comb begin
    raw = {1'b0, minuend_in} - {1'b0, subtrahend_in} - {{DIGIT_W{1'b0}}, borrow_in};
    borrow_out = raw[DIGIT_W];
    // wrapped digit gets the radix back
    if (raw[DIGIT_W]) begin
      diff_out = DIGIT_W'(raw + `BCD_RADIX);
    end else begin
      diff_out = raw[DIGIT_W-1:0];
    end
    bad_digit_out = (minuend_in > `BCD_DIGIT_MAX) || (subtrahend_in > `BCD_DIGIT_MAX);
  end

endmodule : bcd_digit_sub

`default_nettype wire

// File: rtl/accumulator_add_sub_unit.sv
// accumulator datapath: real add/subtract, 16/32-bit BCD subtract, status flags
`default_nettype none
`include "acc_unit_defines.svh"

module accumulator_add_sub_unit #(
  parameter int BCD_DIGITS = `BCD_DIGITS
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  // register port
  input wire logic [`REG_ADDR_W-1:0] addr_in,
  input wire logic [31:0] wr_data_in,
  input wire logic wr_strobe_in,
  input wire logic rd_strobe_in,
  output logic [31:0] rd_data_out,
  // memory interface
  input wire logic ptr_valid_in,
  // results
  output logic [31:0] acc_out,
  output logic [`FLG_W-1:0] flags_out,
  output logic busy_out,
  output logic done_out
);

  // ==================================================================
  // state
  typedef struct packed {
    acc_unit_pkg::fsm_t fsm;
    logic [31:0] acc;
    logic [31:0] operand;
    acc_unit_pkg::op_t op;
    acc_unit_pkg::src_t src;
    logic ptr_bad;
    logic [`FLG_W-1:0] flags;
    logic [31:0] rd_data;
    logic done;
  } unit_state_t;

  unit_state_t state_ff;
  unit_state_t nxt_state;

  // ==================================================================
  // real adder: returns {underflow, overflow, result}
  // rounding is by truncation; a denormal counts as zero
  function automatic logic [33:0] real_add(input logic [31:0] a, input logic [31:0] b);
    logic [7:0] ea;
    logic [7:0] eb;
    logic [7:0] eh;
    logic [7:0] el;
    logic [23:0] ma;
    logic [23:0] mb;
    logic [23:0] mh;
    logic [23:0] ml;
    logic [23:0] mla;
    logic sh;
    logic sl;
    logic [8:0] diff;
    logic [24:0] sum;
    logic [4:0] lz;
    logic [9:0] er;
    logic [23:0] mr;
    logic uf;
    logic ovf;
    logic [31:0] res;
    ea = a[30:23];
    eb = b[30:23];
    ma = (ea == `FP_EXP_ZERO) ? 24'h000000 : {1'b1, a[22:0]};
    mb = (eb == `FP_EXP_ZERO) ? 24'h000000 : {1'b1, b[22:0]};
    // larger magnitude drives sign and exponent
    if ({eb, mb} > {ea, ma}) begin
      sh = b[31];
      eh = eb;
      mh = mb;
      sl = a[31];
      el = ea;
      ml = ma;
    end else begin
      sh = a[31];
      eh = ea;
      mh = ma;
      sl = b[31];
      el = eb;
      ml = mb;
    end
    diff = {1'b0, eh} - {1'b0, el};
    if (diff >= `FP_ALIGN_LIMIT) begin
      mla = 24'h000000;
    end else begin
      mla = ml >> diff;
    end
    if (sh == sl) begin
      sum = {1'b0, mh} + {1'b0, mla};
    end else begin
      sum = {1'b0, mh} - {1'b0, mla};
    end
    lz = 5'h00;
    for (int i = 0; i < `FP_MANT_W; i++) begin
      if (sum[i]) begin
        lz = 5'(`FP_MANT_W - 1 - i);
      end
    end
    if (sum[24]) begin
      mr = sum[24:1];
      er = {2'b00, eh} + `FP_EXP_ONE;
    end else begin
      mr = sum[23:0] << lz;
      er = {2'b00, eh} - {5'h00, lz};
    end
    uf = 1'b0;
    ovf = 1'b0;
    if (sum == 25'h0000000) begin
      res = 32'h0000_0000;
    end else if (er[9] || er == 10'h000) begin
      uf = 1'b1;
      res = {sh, 31'h0000_0000};
    end else if (er >= `FP_EXP_OVF) begin
      ovf = 1'b1;
      res = {sh, `FP_EXP_ALL1, 23'h000000};
    end else begin
      res = {sh, er[7:0], mr[22:0]};
    end
    return {uf, ovf, res};
  endfunction : real_add

  // ==================================================================
  // BCD subtractor chain
  logic op_is_bcd16;
  logic [31:0] bcd_a;
  logic [31:0] bcd_b;
  logic [31:0] bcd_diff;
  logic [BCD_DIGITS:0] borrow_chain;
  logic [BCD_DIGITS-1:0] bad_digit;

  assign op_is_bcd16 = (state_ff.op == acc_unit_pkg::sub_bcd16_op);
  // only the low half takes part
  assign bcd_a = op_is_bcd16 ? {16'h0000, state_ff.acc[`HALF_W-1:0]} : state_ff.acc;
  assign bcd_b = op_is_bcd16 ? {16'h0000, state_ff.operand[`HALF_W-1:0]} : state_ff.operand;
  assign borrow_chain[0] = 1'b0;

  genvar gd;
  generate
    for (gd = 0; gd < BCD_DIGITS; gd++) begin : g_digit
      bcd_digit_sub #(
        .DIGIT_W(4)
      ) u_digit (
        .minuend_in(bcd_a[gd*4 +: 4]),
        .subtrahend_in(bcd_b[gd*4 +: 4]),
        .borrow_in(borrow_chain[gd]),
        .diff_out(bcd_diff[gd*4 +: 4]),
        .borrow_out(borrow_chain[gd+1]),
        .bad_digit_out(bad_digit[gd])
      );
    end
  endgenerate

  // ==================================================================
  // next state
  always_comb begin
    logic [31:0] operand_r;
    logic [33:0] fres;
    logic [31:0] result;
    logic fmt_bad;
    logic borrow16;
    logic borrow32;
    operand_r = 32'h0000_0000;
    fres = 34'h0_0000_0000;
    result = 32'h0000_0000;
    fmt_bad = 1'b0;
    borrow16 = borrow_chain[`HALF_W/4];
    borrow32 = borrow_chain[BCD_DIGITS];
    nxt_state = state_ff;
    nxt_state.done = 1'b0;
    nxt_state.rd_data = `RD_RST;

    // register reads see the state before this edge
    if (rd_strobe_in) begin
      if (addr_in == `REG_ACC) begin
        nxt_state.rd_data = state_ff.acc;
      end else if (addr_in == `REG_OPERAND) begin
        nxt_state.rd_data = state_ff.operand;
      end else if (addr_in == `REG_CMD) begin
        nxt_state.rd_data = {28'h0000000, state_ff.src, state_ff.op};
      end else if (addr_in == `REG_STATUS) begin
        nxt_state.rd_data = {22'h000000, state_ff.fsm == acc_unit_pkg::st_exec,
                             state_ff.flags};
      end else begin
        nxt_state.rd_data = `RD_RST;
      end
    end

    // operand may be rewritten at any time; exec uses the held copy
    if (wr_strobe_in && addr_in == `REG_OPERAND) begin
      nxt_state.operand = wr_data_in;
    end

    case (state_ff.fsm)
      acc_unit_pkg::st_idle: begin
        if (wr_strobe_in && addr_in == `REG_ACC) begin
          nxt_state.acc = wr_data_in;
        end else if (wr_strobe_in && addr_in == `REG_CMD) begin
          nxt_state.op = acc_unit_pkg::op_t'(wr_data_in[`CMD_OP_MSB:`CMD_OP_LSB]);
          nxt_state.src = acc_unit_pkg::src_t'(wr_data_in[`CMD_SRC_MSB:`CMD_SRC_LSB]);
          // pointer validity caught with the command
          nxt_state.ptr_bad = (acc_unit_pkg::src_t'(wr_data_in[`CMD_SRC_MSB:`CMD_SRC_LSB])
                               == acc_unit_pkg::src_pointer) && !ptr_valid_in;
          nxt_state.fsm = acc_unit_pkg::st_exec;
        end
      end

      acc_unit_pkg::st_exec: begin
        // writes to accumulator or command are dropped for this one cycle
        nxt_state.fsm = acc_unit_pkg::st_idle;
        nxt_state.done = 1'b1;
        if (state_ff.op == acc_unit_pkg::add_real_op ||
            state_ff.op == acc_unit_pkg::sub_real_op) begin
          // subtract is add of the negated operand
          if (state_ff.op == acc_unit_pkg::sub_real_op) begin
            operand_r = {~state_ff.operand[31], state_ff.operand[30:0]};
          end else begin
            operand_r = state_ff.operand;
          end
          // NaN or infinity on either side
          fmt_bad = (state_ff.acc[30:23] == `FP_EXP_ALL1) ||
                    (state_ff.operand[30:23] == `FP_EXP_ALL1);
          fres = real_add(state_ff.acc, operand_r);
          if (state_ff.ptr_bad || fmt_bad) begin
            result = state_ff.acc;
          end else begin
            result = fres[31:0];
          end
          nxt_state.acc = result;
          nxt_state.flags[`FLG_ZERO] = (result[30:0] == 31'h0000_0000);
          nxt_state.flags[`FLG_NEG] = result[31] && (result[30:0] != 31'h0000_0000);
          nxt_state.flags[`FLG_BADPTR] = state_ff.ptr_bad;
          nxt_state.flags[`FLG_INVFLT] = (result[30:23] == `FP_EXP_ALL1);
          nxt_state.flags[`FLG_SIGNERR] = !state_ff.ptr_bad && !fmt_bad && fres[32];
          nxt_state.flags[`FLG_UNDERFLOW] = !state_ff.ptr_bad && !fmt_bad && fres[33];
          nxt_state.flags[`FLG_OPFMT] = fmt_bad;
          // carry flags untouched by real ops
          nxt_state.flags[`FLG_CARRY16] = state_ff.flags[`FLG_CARRY16];
          nxt_state.flags[`FLG_CARRY32] = state_ff.flags[`FLG_CARRY32];
        end else begin
          fmt_bad = |bad_digit;
          if (fmt_bad) begin
            result = state_ff.acc;
          end else if (op_is_bcd16) begin
            result = {16'h0000, bcd_diff[`HALF_W-1:0]};
          end else begin
            result = bcd_diff;
          end
          nxt_state.acc = result;
          nxt_state.flags[`FLG_ZERO] = (result == 32'h0000_0000);
          // each width has its own tap: borrow out of the fourth digit for 16-bit, out of the last for 32-bit
          nxt_state.flags[`FLG_CARRY16] = !fmt_bad && borrow16;
          nxt_state.flags[`FLG_CARRY32] = !fmt_bad && borrow32;
          // a borrowed result is a negative value
          nxt_state.flags[`FLG_NEG] = !fmt_bad && (op_is_bcd16 ? borrow16 : borrow32);
          nxt_state.flags[`FLG_OPFMT] = fmt_bad;
          nxt_state.flags[`FLG_BADPTR] = state_ff.flags[`FLG_BADPTR];
          nxt_state.flags[`FLG_INVFLT] = state_ff.flags[`FLG_INVFLT];
          nxt_state.flags[`FLG_SIGNERR] = state_ff.flags[`FLG_SIGNERR];
          nxt_state.flags[`FLG_UNDERFLOW] = state_ff.flags[`FLG_UNDERFLOW];
        end
      end

      default: begin
        nxt_state.fsm = acc_unit_pkg::st_idle;
      end
    endcase
  end

  // ==================================================================
  // state register
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_ff.fsm <= acc_unit_pkg::st_idle;
      state_ff.acc <= `ACC_RST;
      state_ff.operand <= `OPERAND_RST;
      state_ff.op <= acc_unit_pkg::add_real_op;
      state_ff.src <= acc_unit_pkg::src_direct;
      state_ff.ptr_bad <= 1'b0;
      state_ff.flags <= `FLG_RST;
      state_ff.rd_data <= `RD_RST;
      state_ff.done <= 1'b0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ==================================================================
  // outputs, all straight from the state register
  assign rd_data_out = state_ff.rd_data;
  assign acc_out = state_ff.acc;
  assign flags_out = state_ff.flags;
  assign busy_out = state_ff.fsm[1];
  assign done_out = state_ff.done;

endmodule : accumulator_add_sub_unit

`default_nettype wire

// File: sim/acc_unit_sva.sv
// checker of the accumulator unit's timing and status flags
`default_nettype none
`include "acc_unit_defines.svh"

module acc_unit_sva #(
  parameter int BCD_DIGITS = 8
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  // register port
  input wire logic [`REG_ADDR_W-1:0] addr_in,
  input wire logic [31:0] wr_data_in,
  input wire logic wr_strobe_in,
  input wire logic rd_strobe_in,
  input wire logic [31:0] rd_data_out,
  // memory interface
  input wire logic ptr_valid_in,
  // results
  input wire logic [31:0] acc_out,
  input wire logic [`FLG_W-1:0] flags_out,
  input wire logic busy_out,
  input wire logic done_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  // ==================================================================
  // op in flight; real ops are codes 0 and 3
  logic [1:0] op_ff;
  logic real_op;
  logic ok;
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      op_ff <= 2'h0;
    end else if (wr_strobe_in && addr_in == `REG_CMD && !busy_out) begin
      op_ff <= wr_data_in[`CMD_OP_MSB:`CMD_OP_LSB];
    end
  end
  assign real_op = op_ff[0] == op_ff[1];
  assign ok = done_out && !flags_out[`FLG_OPFMT] && !flags_out[`FLG_BADPTR];
  // ==================================================================
  cmd_to_done_a: assert property (
    wr_strobe_in && addr_in == `REG_CMD && !busy_out |=> busy_out ##1 (done_out && !busy_out))
    else $error("command not executed in two cycles");
  done_pulse_a: assert property (done_out |=> !done_out)
    else $error("done longer than one cycle");
  flags_hold_a: assert property (!done_out |-> $stable(flags_out))
    else $error("flags moved without an operation");
  acc_hold_a: assert property (
    !done_out && !$past(wr_strobe_in && addr_in == `REG_ACC) |-> $stable(acc_out))
    else $error("accumulator moved without cause");
  rd_idle_a: assert property (!rd_strobe_in |=> rd_data_out == 32'h0)
    else $error("read data without a read");
  acc_read_a: assert property (rd_strobe_in && addr_in == `REG_ACC |=> rd_data_out == $past(acc_out))
    else $error("accumulator read wrong");
  real_zero_a: assert property (
    ok && real_op |-> flags_out[`FLG_ZERO] == (acc_out[30:0] == 31'h0))
    else $error("real zero flag wrong");
  real_neg_a: assert property (
    ok && real_op |-> flags_out[`FLG_NEG] == (acc_out[31] && acc_out[30:0] != 31'h0))
    else $error("real negative flag wrong");
  bcd_zero_a: assert property (ok && !real_op |-> flags_out[`FLG_ZERO] == (acc_out == 32'h0))
    else $error("bcd zero flag wrong");
  bcd16_upper_a: assert property (ok && op_ff == 2'h1 |-> acc_out[31:16] == 16'h0)
    else $error("bcd16 upper half not clear");
  bcd32_neg_a: assert property (
    ok && op_ff == 2'h2 |-> flags_out[`FLG_NEG] == flags_out[`FLG_CARRY32])
    else $error("bcd32 negative differs from borrow");
  real_keep_a: assert property (
    done_out && real_op |-> flags_out[2:1] == $past(flags_out[2:1]))
    else $error("real op changed carry flags");
  bcd_keep_a: assert property (
    done_out && !real_op |-> flags_out[7:4] == $past(flags_out[7:4]))
    else $error("bcd op changed real flags");
  bad_digit_a: assert property (
    done_out && !real_op && flags_out[`FLG_OPFMT] |-> acc_out == $past(acc_out))
    else $error("bad digit changed accumulator");
endmodule : acc_unit_sva

bind accumulator_add_sub_unit acc_unit_sva #(.BCD_DIGITS(BCD_DIGITS)) acc_unit_sva_inst (
  .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .addr_in(addr_in),
  .wr_data_in(wr_data_in), .wr_strobe_in(wr_strobe_in), .rd_strobe_in(rd_strobe_in),
  .rd_data_out(rd_data_out), .ptr_valid_in(ptr_valid_in), .acc_out(acc_out),
  .flags_out(flags_out), .busy_out(busy_out), .done_out(done_out));

`default_nettype wire

// File: sim/ptr_target_model.sv
// word memory model answering the pointer target check
`default_nettype none
`include "acc_unit_defines.svh"

module ptr_target_model (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  // command watch
  input wire logic [`REG_ADDR_W-1:0] addr_in,
  input wire logic [31:0] wr_data_in,
  input wire logic wr_strobe_in,
  // target choice
  input wire logic target_ok_in,
  // answer
  output logic ptr_valid_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic ptr_cmd;
  logic junk_ff;
  // line undriven between lookups: toggle so no stale answer lingers
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      junk_ff <= 1'b0;
    end else begin
      junk_ff <= !junk_ff;
    end
  end
  assign ptr_cmd = wr_strobe_in && addr_in == `REG_CMD
    && wr_data_in[`CMD_SRC_MSB:`CMD_SRC_LSB] == 2'h1;
  assign ptr_valid_out = ptr_cmd ? target_ok_in : junk_ff;
endmodule : ptr_target_model

`default_nettype wire

// File: sim/tb_top.sv
// self-checking bench of the accumulator add/subtract unit
`default_nettype none
`include "acc_unit_defines.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [31:0] acc;
    logic [31:0] opnd;
    logic [3:0] cmd;
    logic ptr_ok;
    logic [31:0] exp_acc;
    logic [8:0] exp_flg;
  } row_t;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wr_data = 32'h0;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic target_ok = 1'b1;
  logic ptr_valid;
  logic [31:0] rd_data;
  logic [31:0] acc;
  logic [`FLG_W-1:0] flags;
  logic busy;
  logic done;
  logic [31:0] got;
  int n_errors = 0;
  int check_count = 0;
  // ==================================================================
  // cmd is {source, op}; flags carry over from row to row
  // real operands in IEEE single format, no constant on bcd16
  row_t rows [15] = '{
    '{32'h40E00000, 32'h41700000, 4'h4, 1'b1, 32'h41B00000, 9'h000},
    '{32'h3F800000, 32'h40400000, 4'h3, 1'b1, 32'hC0000000, 9'h008},
    '{32'h40A00000, 32'h40A00000, 4'hB, 1'b1, 32'h00000000, 9'h001},
    '{32'h4B800000, 32'h3F800000, 4'h8, 1'b1, 32'h4B800000, 9'h000},
    '{32'h40000000, 32'h7F800000, 4'h0, 1'b1, 32'h40000000, 9'h100},
    '{32'h3F800000, 32'h3F800000, 4'h4, 1'b0, 32'h3F800000, 9'h010},
    '{32'h7F7FFFFF, 32'h7F7FFFFF, 4'h0, 1'b1, 32'h7F800000, 9'h060},
    '{32'h00800001, 32'h00800000, 4'h3, 1'b1, 32'h00000000, 9'h081},
    '{32'h00000050, 32'h00000023, 4'h1, 1'b1, 32'h00000027, 9'h080},
    '{32'h12340010, 32'h00000020, 4'h5, 1'b1, 32'h00009990, 9'h08E},
    '{32'h00010000, 32'h00000001, 4'hA, 1'b1, 32'h00009999, 9'h082},
    '{32'h00000005, 32'h00000007, 4'h2, 1'b1, 32'h99999998, 9'h08E},
    '{32'h3F800000, 32'h3F800000, 4'h0, 1'b1, 32'h40000000, 9'h006},
    '{32'h12345678, 32'h12345678, 4'h2, 1'b1, 32'h00000000, 9'h001},
    '{32'h000000A0, 32'h00000001, 4'h1, 1'b1, 32'h000000A0, 9'h100}
  };
  always #50 sys_clk = !sys_clk;
  ptr_target_model ptr_target_model_inst (.sys_clk_in(sys_clk), .reset_n_in(reset_n),
    .addr_in(addr), .wr_data_in(wr_data), .wr_strobe_in(wr_stb), .target_ok_in(target_ok),
    .ptr_valid_out(ptr_valid));
  accumulator_add_sub_unit #(.BCD_DIGITS(8)) accumulator_add_sub_unit_inst (
    .sys_clk_in(sys_clk), .reset_n_in(reset_n), .addr_in(addr), .wr_data_in(wr_data),
    .wr_strobe_in(wr_stb), .rd_strobe_in(rd_stb), .rd_data_out(rd_data),
    .ptr_valid_in(ptr_valid), .acc_out(acc), .flags_out(flags), .busy_out(busy),
    .done_out(done));
  // ==================================================================
  // bus cycles and checks
  task automatic cyc(input logic wr, input logic rd, input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    wr_stb <= wr;
    rd_stb <= rd;
    addr <= a;
    wr_data <= d;
  endtask : cyc
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    cyc(1'b0, 1'b1, a, 32'h0);
    cyc(1'b0, 1'b0, 4'h0, 32'h0);
    #1;
    d = rd_data;
  endtask : rd_reg
  task automatic wait_done();
    cyc(1'b0, 1'b0, 4'h0, 32'h0);
    for (int i = 0; i < 8; i++) begin
      @(posedge sys_clk);
      #1;
      if (done === 1'b1) return;
    end
    check("done", 32'h0, 32'h1);
  endtask : wait_done
  task automatic run_row(input row_t r);
    cyc(1'b1, 1'b0, `REG_ACC, r.acc);
    cyc(1'b1, 1'b0, `REG_OPERAND, r.opnd);
    target_ok <= r.ptr_ok;
    cyc(1'b1, 1'b0, `REG_CMD, {28'h0, r.cmd});
    wait_done();
    check("acc", acc, r.exp_acc);
    check("flags", {23'h0, flags}, {23'h0, r.exp_flg});
  endtask : run_row
  task automatic do_reset();
    @(posedge sys_clk);
    reset_n <= 1'b0;
    // strobes must not stand across the release
    wr_stb <= 1'b0;
    rd_stb <= 1'b0;
    repeat (16) @(posedge sys_clk);
    #1;
    check("reset acc", acc, 32'h0);
    check("reset flags", {21'h0, flags, rd_data[31:30]}, 32'h0);
    check("reset ctl", {rd_data[29:0], busy, done}, 32'h0);
    @(posedge sys_clk);
    reset_n <= 1'b1;
  endtask : do_reset
  task automatic print_verdict();
    if (n_errors == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict
  // ==================================================================
  initial begin
    do_reset();
    foreach (rows[i]) begin
      run_row(rows[i]);
    end
    // accumulator write dropped while busy
    cyc(1'b1, 1'b0, `REG_ACC, 32'h3F800000);
    cyc(1'b1, 1'b0, `REG_OPERAND, 32'h3F800000);
    cyc(1'b1, 1'b0, `REG_CMD, 32'h0);
    cyc(1'b1, 1'b0, `REG_ACC, 32'h12345678);
    repeat (3) cyc(1'b0, 1'b0, 4'h0, 32'h0);
    #1;
    check("acc busy write", acc, 32'h40000000);
    // second command back to back is dropped
    cyc(1'b1, 1'b0, `REG_CMD, 32'h3);
    cyc(1'b1, 1'b0, `REG_CMD, 32'h0);
    repeat (3) cyc(1'b0, 1'b0, 4'h0, 32'h0);
    #1;
    check("acc busy cmd", acc, 32'h3F800000);
    // next command in the done cycle is taken
    cyc(1'b1, 1'b0, `REG_CMD, 32'h0);
    cyc(1'b0, 1'b0, 4'h0, 32'h0);
    cyc(1'b1, 1'b0, `REG_CMD, 32'h0);
    wait_done();
    check("acc chained", acc, 32'h40400000);
    cyc(1'b1, 1'b0, `REG_STATUS, 32'hFFFFFFFF);
    rd_reg(`REG_STATUS, got);
    check("status", got, 32'h0);
    rd_reg(4'hF, got);
    check("unmapped", got, 32'h0);
    rd_reg(`REG_ACC, got);
    check("acc read", got, 32'h40400000);
    // reset in mid operation
    cyc(1'b1, 1'b0, `REG_CMD, 32'h0);
    do_reset();
    // first operation after the mid-run reset starts from cleared flags
    run_row(rows[0]);
    print_verdict();
  end
  initial begin
    #200000;
    n_errors++;
    print_verdict();
  end
endmodule : tb_top

`default_nettype wire
